// *** bench/tb_top.sv ***
// Self-checking testbench for the host port suspend and resume block
`timescale 1ns/1ps
module tb_top;
    import uhpsr_pkg::*;
    localparam int MFP = 16;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] reg_addr = 8'h00;
    logic [DATA_W-1:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic wake_req = 1'b0;
    logic [7:0] hs_delay = 8'h28;
    logic [DATA_W-1:0] reg_rdata;
    logic [1:0] line_state;
    logic remote_wake, phy_hs_mode, port_suspend, port_resume_drive, sof_pulse, irq;
    int fails = 0;
    int tests_run = 0;
    int sof_cnt = 0;

    always #5 clk_sys = ~clk_sys;
    // Counted on the falling edge so a read at a rising edge never races the count
    always @(negedge clk_sys) if (sof_pulse === 1'b1) sof_cnt++;

    uhpsr_port #(.MF_PERIOD(MFP)) uhpsr_port_inst (.clk_sys(clk_sys), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .line_state(line_state), .remote_wake(remote_wake),
        .phy_hs_mode(phy_hs_mode), .port_suspend(port_suspend),
        .port_resume_drive(port_resume_drive), .sof_pulse(sof_pulse), .irq(irq));
    uhpsr_phy_model uhpsr_phy_model_inst (.clk_sys(clk_sys), .reset(reset),
        .phy_hs_mode(phy_hs_mode), .port_suspend(port_suspend),
        .port_resume_drive(port_resume_drive), .wake_req(wake_req), .hs_delay(hs_delay),
        .line_state(line_state), .remote_wake(remote_wake));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read

    // Wait until the frame index has moved on, so a write lands a few cycles after a frame start
    task automatic poll_frame();
        logic [31:0] f0, f1;
        reg_read(REG_FRINDEX, f0);
        f1 = f0;
        for (int n = 0; n < 40 && f1 === f0; n++) reg_read(REG_FRINDEX, f1);
        check(32'(f1 != f0), 32'h1);
    endtask : poll_frame

    task automatic t_reset();
        logic [31:0] d;
        reg_read(REG_STS, d);
        check(d, 32'h1);
        reg_read(REG_CMD, d);
        check(d, 32'h0);
        reg_write(8'h20, 32'hFFFF_FFFF);
        reg_read(8'h20, d);
        check(d, 32'h0);
        check({28'h0, irq, port_resume_drive, port_suspend, phy_hs_mode}, 32'h1);
    endtask : t_reset

    task automatic t_run();
        logic [31:0] d, f0, f1;
        int s;
        reg_write(REG_CMD, 32'h1);
        reg_read(REG_FRINDEX, d);
        check(d, 32'h0);
        reg_read(REG_STS, d);
        check(d, 32'h0);
        s = sof_cnt;
        repeat (4 * MFP) @(posedge clk_sys);
        check(32'(sof_cnt - s), 32'h4);
        reg_read(REG_FRINDEX, f0);
        repeat (3 * MFP - 2) @(posedge clk_sys);
        reg_read(REG_FRINDEX, f1);
        check(f1 - f0, 32'h3);
        reg_write(REG_MASK, 32'h2);
    endtask : t_run

    task automatic t_suspend_resume();
        logic [31:0] d, f0, f1;
        int s;
        poll_frame();
        reg_write(REG_PORT, 32'h1);
        #1 check({30'h0, port_suspend, phy_hs_mode}, 32'h2);
        s = sof_cnt;
        reg_read(REG_FRINDEX, f0);
        repeat (3 * MFP - 2) @(posedge clk_sys);
        reg_read(REG_FRINDEX, f1);
        check(f1 - f0, 32'h3);
        check(32'(sof_cnt - s), 32'h0);
        poll_frame();
        reg_write(REG_PORT, 32'h2);
        repeat (2) @(posedge clk_sys);
        #1 check({31'h0, port_resume_drive}, 32'h1);
        // Shortened stand-in for the long resume hold
        repeat (200) @(posedge clk_sys);
        poll_frame();
        reg_write(REG_PORT, 32'h0);
        for (int n = 0; n < 8 && phy_hs_mode !== 1'b1; n++) @(posedge clk_sys);
        s = sof_cnt;
        repeat (30) @(posedge clk_sys);
        check(32'(sof_cnt - s), 32'h0);
        repeat (20 + 2 * MFP) @(posedge clk_sys);
        check(32'(sof_cnt != s), 32'h1);
        reg_read(REG_PORT, d);
        check(d, 32'hC);
        reg_read(REG_STS, d);
        check(d, 32'h4);
        check({31'h0, irq}, 32'h0);
        reg_write(REG_STS, 32'h4);
        reg_read(REG_STS, d);
        check(d, 32'h0);
    endtask : t_suspend_resume

    task automatic t_remote_wake();
        logic [31:0] d;
        int s;
        reg_write(REG_PORT, 32'h1);
        wake_req <= 1'b1;
        for (int n = 0; n < 8 && irq !== 1'b1; n++) @(posedge clk_sys);
        #1 check({31'h0, irq}, 32'h1);
        reg_read(REG_STS, d);
        check(d, 32'h2);
        reg_read(REG_PORT, d);
        check(d, 32'h3);
        @(posedge clk_sys);
        wake_req <= 1'b0;
        repeat (200) @(posedge clk_sys);
        reg_write(REG_CMD, 32'h0);
        d = 32'h0;
        for (int n = 0; n < 20 && d[0] !== 1'b1; n++) reg_read(REG_STS, d);
        check({31'h0, d[0]}, 32'h1);
        reg_write(REG_PORT, 32'h0);
        reg_write(REG_CMD, 32'h1);
        reg_read(REG_FRINDEX, d);
        check(d, 32'h0);
        reg_write(REG_STS, 32'h2);
        repeat (2) @(posedge clk_sys);
        #1 check({31'h0, irq}, 32'h0);
        s = sof_cnt;
        repeat (50 + 2 * MFP) @(posedge clk_sys);
        check(32'(sof_cnt != s), 32'h1);
    endtask : t_remote_wake

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        summarize();
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        t_reset();
        t_run();
        t_suspend_resume();
        t_remote_wake();
        summarize();
    end
endmodule : tb_top

// *** bench/uhpsr_phy_model.sv ***
// Behavioural PHY and attached device on the far side of the host port
`timescale 1ns/1ps
module uhpsr_phy_model (
    input wire logic clk_sys, // System clock
    input wire logic reset, // Synchronous reset
    input wire logic phy_hs_mode, // Host asks for high-speed
    input wire logic port_suspend, // Port suspended
    input wire logic port_resume_drive, // Host drives resume
    input wire logic wake_req, // Bench asks the device to wake
    input wire logic [7:0] hs_delay, // Cycles before high-speed idle shows
    output logic [1:0] line_state, // Reported line state
    output logic remote_wake // Device resume signalling
);
    logic [7:0] hs_cnt;
    always @(posedge clk_sys) begin
        if (reset || !phy_hs_mode) begin
            hs_cnt <= 8'h00;
        end else if (hs_cnt != hs_delay) begin
            hs_cnt <= hs_cnt + 8'h01;
        end
        // Device stops signalling once the host takes over resume
        if (reset || port_resume_drive) begin
            remote_wake <= 1'b0;
        end else if (wake_req && port_suspend) begin
            remote_wake <= 1'b1;
        end
    end
    // Slow switch: line is busy until the delay has passed
    assign line_state = !phy_hs_mode ? 2'h1 : ((hs_cnt == hs_delay) ? 2'h0 : 2'h2);
endmodule : uhpsr_phy_model

// *** hw/uhpsr_fc_if.sv ***
// Connection between the port logic and one frame counter
`timescale 1ns/1ps
interface uhpsr_fc_if #(parameter int PH_W = 14, parameter int IDX_W = 14);
    logic enable;
    logic align;
    logic tick;
    logic [PH_W-1:0] phase;
    logic [IDX_W-1:0] index;
    modport ctr (input enable, input align, output tick, output phase, output index);
    modport user (output enable, output align, input tick, input phase, input index);
endinterface : uhpsr_fc_if

// *** hw/uhpsr_frame_ctr.sv ***
// Micro-frame counter: phase within the period and frame index
`timescale 1ns/1ps
module uhpsr_frame_ctr #(
    parameter int PERIOD_CYCLES = 12500,
    parameter int IDX_W = 14
) (
    input wire logic clk_sys, // System clock
    input wire logic reset, // Synchronous reset
    uhpsr_fc_if.ctr fc // Counter control and state
);
    localparam int PH_W = $clog2(PERIOD_CYCLES);
    localparam logic [PH_W-1:0] PH_LAST = PH_W'(PERIOD_CYCLES - 1);

    generate
        if (PERIOD_CYCLES < 2 || IDX_W < 1) begin : g_bad
            $error("uhpsr_frame_ctr: period or index width out of range");
        end
    endgenerate

    logic [PH_W-1:0] phase;
    logic [PH_W-1:0] next_phase;
    logic [IDX_W-1:0] index;
    logic [IDX_W-1:0] next_index;
    logic wrap;

    assign wrap = fc.enable && !fc.align && (phase == PH_LAST);
    assign fc.tick = wrap;
    assign fc.phase = phase;
    assign fc.index = index;

    always_comb begin
        next_phase = phase;
        next_index = index;
        if (fc.align) begin
            next_phase = '0;
            next_index = '0;
        end else if (wrap) begin
            next_phase = '0;
            next_index = index + IDX_W'(1);
        end else if (fc.enable) begin
            next_phase = phase + PH_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            phase <= '0;
            index <= '0;
        end else begin
            phase <= next_phase;
            index <= next_index;
        end
    end
endmodule : uhpsr_frame_ctr

// *** hw/uhpsr_pkg.sv ***
// Constants and types for the host port suspend and resume block
package uhpsr_pkg;
    // Clock and micro-frame timing
    localparam int CLK_MHZ = 100;
    localparam int MF_TIME_US = 125;
    localparam int MF_CYCLES = MF_TIME_US * CLK_MHZ;
    localparam int IDX_W = 14;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register offsets
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_STS = 8'h04;
    localparam logic [7:0] REG_MASK = 8'h08;
    localparam logic [7:0] REG_FRINDEX = 8'h0C;
    localparam logic [7:0] REG_PORT = 8'h10;

    // Field positions
    localparam int CMD_RUN_BIT = 0;
    localparam int STS_HALTED_BIT = 0;
    localparam int STS_EVT_LSB = 1;
    localparam int EVT_W = 2;
    localparam int EVT_WAKE = 0;
    localparam int EVT_RDONE = 1;
    localparam int PORT_SUSP_BIT = 0;
    localparam int PORT_FRES_BIT = 1;
    localparam int PORT_IDLE_BIT = 2;
    localparam int PORT_HSM_BIT = 3;

    // Reset values
    localparam logic RUN_RST = 1'b0;
    localparam logic HALTED_RST = 1'b1;
    localparam logic [1:0] EVT_RST = 2'h0;

    // Line state that reads as high-speed idle
    localparam logic [1:0] LS_HS_IDLE = 2'h0;

    typedef enum logic [3:0] {
        ST_ACTIVE = 4'h1,
        ST_SUSPEND = 4'h2,
        ST_RESUME = 4'h4,
        ST_HS_WAIT = 4'h8
    } uhpsr_port_st_t;
endpackage : uhpsr_pkg

// *** hw/uhpsr_port.sv ***
// Host port suspend, resume and remote wakeup control with frame counters
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module uhpsr_port
    import uhpsr_pkg::*;
#(
    parameter int MF_PERIOD = MF_CYCLES
) (
    input wire logic clk_sys, // System clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic [ADDR_W-1:0] reg_addr, // Register byte address
    input wire logic [DATA_W-1:0] reg_wdata, // Register write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
    input wire logic [1:0] line_state, // Bus line state from the PHY
    input wire logic remote_wake, // Device resume signalling seen
    output logic phy_hs_mode, // PHY in high-speed mode
    output logic port_suspend, // Port held in suspend
    output logic port_resume_drive, // Host drives resume signalling
    output logic sof_pulse, // Start of micro-frame on the port
    output logic irq // Interrupt, level
);
    localparam int PH_W = $clog2(MF_PERIOD);

    generate
        if (MF_PERIOD < 2) begin : g_bad
            $error("uhpsr_port: micro-frame period too short");
        end
    endgenerate

    uhpsr_fc_if #(.PH_W(PH_W), .IDX_W(IDX_W)) gfc ();
    uhpsr_fc_if #(.PH_W(PH_W), .IDX_W(IDX_W)) pfc ();

    uhpsr_frame_ctr #(.PERIOD_CYCLES(MF_PERIOD), .IDX_W(IDX_W)) u_glob (
        .clk_sys(clk_sys),
        .reset(reset),
        .fc(gfc)
    );
    uhpsr_frame_ctr #(.PERIOD_CYCLES(MF_PERIOD), .IDX_W(IDX_W)) u_port (
        .clk_sys(clk_sys),
        .reset(reset),
        .fc(pfc)
    );

    uhpsr_port_st_t state;
    uhpsr_port_st_t next_state;
    logic run;
    logic next_run;
    logic halted;
    logic next_halted;
    logic fres;
    logic next_fres;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] next_evt;
    logic [EVT_W-1:0] mask;
    logic [EVT_W-1:0] next_mask;
    logic [DATA_W-1:0] next_rdata;
    logic next_phy_hs;
    logic next_suspend;
    logic next_resume_drive;
    logic next_sof;
    logic next_irq;
    logic wr_cmd;
    logic wr_sts;
    logic wr_mask;
    logic wr_port;
    logic align;
    logic hw_wake;
    logic hs_idle;
    logic resume_done;
    logic suspended;

    assign wr_cmd = reg_wr && (reg_addr == REG_CMD);
    assign wr_sts = reg_wr && (reg_addr == REG_STS);
    assign wr_mask = reg_wr && (reg_addr == REG_MASK);
    assign wr_port = reg_wr && (reg_addr == REG_PORT);
    assign hs_idle = (line_state == LS_HS_IDLE);
    assign suspended = (state == ST_SUSPEND) || (state == ST_RESUME);
    assign align = wr_cmd && reg_wdata[CMD_RUN_BIT] && !run;
    assign hw_wake = (state == ST_SUSPEND) && remote_wake && !fres;
    assign resume_done = (state == ST_HS_WAIT) && hs_idle;

    assign gfc.align = align;
    assign pfc.align = align;
    assign gfc.enable = !halted;
    assign pfc.enable = !halted && (state != ST_SUSPEND);

    // Run control and halted status
    always_comb begin
        next_run = run;
        next_halted = halted;
        if (wr_cmd) begin
            next_run = reg_wdata[CMD_RUN_BIT];
        end
        if (run) begin
            next_halted = 1'b0;
        end else if (gfc.tick) begin
            next_halted = 1'b1;
        end
    end

    // Port state and forced resume bit
    always_comb begin
        next_state = state;
        next_fres = fres;
        if (wr_port && suspended) begin
            next_fres = reg_wdata[PORT_FRES_BIT];
        end
        if (hw_wake) begin
            next_fres = 1'b1;
        end
        if (!suspended) begin
            next_fres = 1'b0;
        end
        case (state)
            ST_ACTIVE: begin
                if (wr_port && reg_wdata[PORT_SUSP_BIT]) begin
                    next_state = ST_SUSPEND;
                end
            end
            ST_SUSPEND: begin
                if (next_fres) begin
                    next_state = ST_RESUME;
                end
            end
            ST_RESUME: begin
                // clear assumed on a frame boundary
                if (!fres) begin
                    next_state = ST_HS_WAIT;
                end
            end
            ST_HS_WAIT: begin
                if (hs_idle) begin
                    next_state = ST_ACTIVE;
                end
            end
            default: begin
                next_state = ST_ACTIVE;
            end
        endcase
    end

    // Sticky events, mask and interrupt; a set wins over a clear
    always_comb begin
        next_evt = evt;
        next_mask = mask;
        if (wr_sts) begin
            next_evt = evt & ~reg_wdata[STS_EVT_LSB +: EVT_W];
        end
        if (wr_mask) begin
            next_mask = reg_wdata[STS_EVT_LSB +: EVT_W];
        end
        if (hw_wake) begin
            next_evt[EVT_WAKE] = 1'b1;
        end
        if (resume_done) begin
            next_evt[EVT_RDONE] = 1'b1;
        end
        next_irq = |(next_evt & next_mask);
    end

    // Registered link outputs
    always_comb begin
        next_phy_hs = (next_state == ST_ACTIVE) || (next_state == ST_HS_WAIT);
        next_suspend = (next_state == ST_SUSPEND);
        next_resume_drive = (next_state == ST_RESUME);
        next_sof = pfc.tick && (state == ST_ACTIVE) && run;
    end

    // Register read port
    always_comb begin
        next_rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                REG_CMD: next_rdata[CMD_RUN_BIT] = run;
                REG_STS: begin
                    next_rdata[STS_HALTED_BIT] = halted;
                    next_rdata[STS_EVT_LSB +: EVT_W] = evt;
                end
                REG_MASK: next_rdata[STS_EVT_LSB +: EVT_W] = mask;
                REG_FRINDEX: next_rdata[IDX_W-1:0] = gfc.index;
                REG_PORT: begin
                    next_rdata[PORT_SUSP_BIT] = (state != ST_ACTIVE);
                    next_rdata[PORT_FRES_BIT] = fres;
                    next_rdata[PORT_IDLE_BIT] = hs_idle;
                    next_rdata[PORT_HSM_BIT] = phy_hs_mode;
                end
                default: next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state <= ST_ACTIVE;
            run <= RUN_RST;
            halted <= HALTED_RST;
            fres <= 1'b0;
            evt <= EVT_RST;
            mask <= EVT_RST;
            reg_rdata <= '0;
            phy_hs_mode <= 1'b1;
            port_suspend <= 1'b0;
            port_resume_drive <= 1'b0;
            sof_pulse <= 1'b0;
            irq <= 1'b0;
        end else begin
            state <= next_state;
            run <= next_run;
            halted <= next_halted;
            fres <= next_fres;
            evt <= next_evt;
            mask <= next_mask;
            reg_rdata <= next_rdata;
            phy_hs_mode <= next_phy_hs;
            port_suspend <= next_suspend;
            port_resume_drive <= next_resume_drive;
            sof_pulse <= next_sof;
            irq <= next_irq;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_wake;
        (state == ST_SUSPEND) && remote_wake && !fres;
    endsequence

    sequence s_hs_busy;
        (state == ST_HS_WAIT) && !hs_idle;
    endsequence

    sequence s_hs_done;
        (state == ST_HS_WAIT) && hs_idle;
    endsequence

    a_hold_till_idle: assert property (s_hs_busy |=> state == ST_HS_WAIT && !sof_pulse)
        else $error("left high-speed wait before idle line state");
    a_port_ctr_halt: assert property ((state == ST_SUSPEND) && $past(state == ST_SUSPEND)
        && !$past(align) |-> $stable(pfc.index) && $stable(pfc.phase))
        else $error("per-port counter moved during suspend");
    a_frame_period: assert property (gfc.tick |-> gfc.phase == PH_W'(MF_PERIOD - 1)
        ##1 gfc.index == $past(gfc.index) + IDX_W'(1))
        else $error("global micro-frame tick off period");
    a_frindex_read: assert property (reg_rd && reg_addr == REG_FRINDEX
        |=> reg_rdata[IDX_W-1:0] == $past(gfc.index))
        else $error("frame index read not from global counter");
    a_run_align: assert property ($rose(run)
        |-> gfc.phase == pfc.phase && gfc.index == pfc.index)
        else $error("counters not aligned when run set");
    a_wake_resume: assert property (s_wake |=> fres && state == ST_RESUME ##1 port_resume_drive)
        else $error("remote wakeup did not set resume");
    a_halt_flag: assert property (!run && gfc.tick |=> halted)
        else $error("halted not set after stop");
    a_halt_run: assert property (halted |-> !$past(run))
        else $error("halted while running");
    a_wake_irq: assert property (s_wake ##0 mask[EVT_WAKE] && !reg_wr |=> irq && evt[EVT_WAKE])
        else $error("wakeup interrupt missing");

    a_sof_gate: assert property (sof_pulse
        |-> $past(pfc.tick) && $past(run) && $past(state == ST_ACTIVE))
        else $error("start of frame outside an active running port");
    a_idle_exit: assert property (s_hs_done
        |=> state == ST_ACTIVE && phy_hs_mode && evt[EVT_RDONE])
        else $error("high-speed wait did not end on idle line state");
    a_glob_in_susp: assert property ((state == ST_SUSPEND) && !halted && !align
        |=> gfc.phase != $past(gfc.phase))
        else $error("global counter stopped during suspend");
    a_halt_freeze: assert property (halted && !align
        |=> $stable(gfc.index) && $stable(gfc.phase))
        else $error("global counter moved while halted");
    a_run_halt_clr: assert property (run |=> !halted)
        else $error("halted still set while running");
    a_resume_out: assert property ((state == ST_RESUME)
        |-> port_resume_drive && !port_suspend && !phy_hs_mode)
        else $error("resume state without resume signalling");
endmodule : uhpsr_port
